// ### sfb_pkg.sv
// package: register map, field positions, tags and modes of the sample buffer
package sfb_pkg;
   localparam logic [7:0] ADDR_TAG = 8'h40;
   localparam logic [7:0] ADDR_X_L = 8'h41;
   localparam logic [7:0] ADDR_Z_H = 8'h46;
   localparam logic [7:0] ADDR_CTRL = 8'h15;
   localparam logic [7:0] ADDR_WTM = 8'h16;
   localparam logic [7:0] ADDR_DEC = 8'h17;
   localparam logic [7:0] ADDR_EMB = 8'h18;
   localparam logic [7:0] ADDR_STAT1 = 8'h19;
   localparam logic [7:0] ADDR_STAT2 = 8'h1a;
   localparam logic [7:0] ADDR_GEN = 8'h1b;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CTRL_MASK = 8'hdf;
   localparam logic [7:0] WTM_RST = 8'h00;
   localparam logic [7:0] DEC_RST = 8'h00;
   localparam logic [7:0] DEC_MASK = 8'h1f;
   localparam logic [7:0] EMB_RST = 8'h00;
   localparam logic [7:0] EMB_MASK = 8'h0f;
   localparam logic [7:0] GEN_RST = 8'h00;
   localparam logic [7:0] GEN_MASK = 8'h0f;
   localparam int CFG_CHG_BIT = 7;
   localparam int DEPTH2X_BIT = 6;
   localparam int ADV_BIT = 4;
   localparam int STOP_TH_BIT = 3;
   localparam int XL_ONLY_BIT = 7;
   localparam int BDU_BIT = 0;
   localparam int IRQ_WTM_BIT = 1;
   localparam int IRQ_OVR_BIT = 2;
   localparam int IRQ_FULL_BIT = 3;
   localparam int DEPTH = 128;
   localparam int CNT_W = 8;
   localparam int IN_DEPTH = 8;
   localparam logic [2:0] MODE_BYPASS = 3'h0;
   localparam logic [2:0] MODE_STOP = 3'h1;
   localparam logic [2:0] MODE_CONT_TO_STOP = 3'h3;
   localparam logic [2:0] MODE_BYP_TO_CONT = 3'h4;
   localparam logic [2:0] MODE_CONT = 3'h6;
   localparam logic [2:0] MODE_BYP_TO_STOP = 3'h7;
   localparam logic [2:0] BDR_OFF = 3'h7;
   localparam logic [4:0] TAG_EMPTY = 5'h00;
   localparam logic [4:0] TAG_XL = 5'h02;
   localparam logic [4:0] TAG_XL_2X = 5'h03;
   localparam logic [4:0] TAG_TS = 5'h04;
   localparam logic [4:0] TAG_STEP = 5'h12;
   localparam logic [4:0] TAG_LRN_RES = 5'h1a;
   localparam logic [4:0] TAG_LRN_FLT = 5'h1b;
   localparam logic [4:0] TAG_LRN_FEAT = 5'h1c;
   localparam logic [4:0] TAG_FSE = 5'h1d;
   localparam logic [4:0] TAG_BIO_ONLY = 5'h1e;
   localparam logic [4:0] TAG_XL_BIO = 5'h1f;
   typedef struct packed {
      logic [4:0] tag;
      logic [47:0] data;
   } sfb_word_t;
   typedef struct packed {
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
      logic [15:0] bio;
   } sfb_sample_t;
   typedef struct packed {
      logic [3:0] output_sample_rate;
      logic [1:0] bw;
      logic hp_en;
      logic [1:0] fs;
      logic [1:0] batch_sample_rate;
   } sfb_cfg_t;
endpackage : sfb_pkg

// ### sfb_top.sv
// sample buffer: batching control, 128-word store, status and readout
//
// Contract
// - config change writes config plus timestamp word
// - double depth stores upper bytes, half rate
// - stop-at-threshold limits depth to watermark
// - mode field in control bits 2..0
// - watermark level seven bits, up to 127
// - watermark flag when count reaches level
// - acceleration-only stores 16-bit axes, no bio
// - timestamp decimation off, 1, 8, 32
// - acceleration batch rate divided by power two
// - separate enables for embedded result batching
// - overrun flag after full buffer overwritten
// - interrupt only through routing enables
// - status tracks every write and read
// - eight-bit count, top bit is full
// - block update holds status until second read
// - main sensor tags in bits 7..3
// - embedded result tags, bits 2..1 zero
// - empty buffer shows tag zero
// - six data bytes at 41h..46h, X first
// - six operating modes supported
// - packed 12-bit axes plus bio sample

////////////////////////////////////////////////////////////////////////////
module sfb_in_fifo #(
   parameter int WIDTH = 53,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_reg;
   logic [AW:0] rp_reg;
   logic full;
   logic empty;
   assign empty = wp_reg == rp_reg;
   assign full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rp_reg[AW-1:0]];
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wp_reg <= '0;
      end else if (in_valid && !full) begin
         wp_reg <= wp_reg + 1'b1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (in_valid && !full) begin
         mem[wp_reg[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rp_reg <= '0;
      end else if (out_ready && !empty) begin
         rp_reg <= rp_reg + 1'b1;
      end
   end
endmodule : sfb_in_fifo

////////////////////////////////////////////////////////////////////////////
module sfb_top (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic odr_tick,
   input wire logic bio_only_state,
   input wire sfb_pkg::sfb_sample_t sample,
   input wire logic [31:0] timestamp,
   input wire sfb_pkg::sfb_cfg_t dev_cfg,
   input wire logic emb_valid,
   input wire logic [4:0] emb_tag,
   input wire logic [47:0] emb_data,
   output logic emb_ready,
   output logic int_out
);
   logic [7:0] ctrl_reg;
   logic [7:0] wtm_reg;
   logic [7:0] dec_reg;
   logic [7:0] emb_reg;
   logic [7:0] gen_reg;
   logic [2:0] mode;
   logic [6:0] level;
   logic wr_ctrl;
   assign mode = ctrl_reg[2:0];
   assign level = wtm_reg[6:0];

   ////////////////////////////////////////////////////////////////////////
   // configuration registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_reg <= sfb_pkg::CTRL_RST;
         wtm_reg <= sfb_pkg::WTM_RST;
         dec_reg <= sfb_pkg::DEC_RST;
         emb_reg <= sfb_pkg::EMB_RST;
         gen_reg <= sfb_pkg::GEN_RST;
      end else if (reg_wr) begin
         if (reg_addr == sfb_pkg::ADDR_CTRL) begin
            ctrl_reg <= reg_wdata & sfb_pkg::CTRL_MASK;
         end else if (reg_addr == sfb_pkg::ADDR_WTM) begin
            wtm_reg <= reg_wdata;
         end else if (reg_addr == sfb_pkg::ADDR_DEC) begin
            dec_reg <= reg_wdata & sfb_pkg::DEC_MASK;
         end else if (reg_addr == sfb_pkg::ADDR_EMB) begin
            emb_reg <= reg_wdata & sfb_pkg::EMB_MASK;
         end else if (reg_addr == sfb_pkg::ADDR_GEN) begin
            gen_reg <= reg_wdata & sfb_pkg::GEN_MASK;
         end
      end
   end
   assign wr_ctrl = reg_wr && reg_addr == sfb_pkg::ADDR_CTRL;

   ////////////////////////////////////////////////////////////////////////
   // batch rate dividers and configuration change detection
   logic [5:0] bdr_cnt_reg;
   logic [4:0] ts_cnt_reg;
   logic half_reg;
   logic cfg_pend_reg;
   sfb_pkg::sfb_cfg_t cfg_last_reg;
   logic [4:0] dec_last_reg;
   logic [5:0] bdr_mask;
   logic [4:0] ts_mask;
   logic xl_hit;
   logic ts_hit;
   logic depth2x;
   logic xl_only;
   logic cfg_change;
   assign depth2x = ctrl_reg[sfb_pkg::DEPTH2X_BIT];
   assign xl_only = wtm_reg[sfb_pkg::XL_ONLY_BIT];
   assign bdr_mask = 6'((7'h01 << dec_reg[2:0]) - 7'h01);
   always_comb begin
      case (dec_reg[4:3])
         2'h2: ts_mask = 5'h07;
         2'h3: ts_mask = 5'h1f;
         default: ts_mask = 5'h00;
      endcase
   end
   assign xl_hit = odr_tick && dec_reg[2:0] != sfb_pkg::BDR_OFF
      && (bdr_cnt_reg & bdr_mask) == 6'h00;
   assign ts_hit = xl_hit && dec_reg[4:3] != 2'h0
      && (ts_cnt_reg & ts_mask) == 5'h00;
   assign cfg_change = cfg_last_reg != dev_cfg || dec_last_reg != dec_reg[4:0];
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bdr_cnt_reg <= '0;
      end else if (odr_tick) begin
         bdr_cnt_reg <= bdr_cnt_reg + 1'b1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ts_cnt_reg <= '0;
      end else if (xl_hit) begin
         ts_cnt_reg <= ts_cnt_reg + 1'b1;
      end
   end
   // double depth pairs two samples: second tick of each pair writes
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         half_reg <= 1'b0;
      end else if (xl_hit) begin
         half_reg <= !half_reg;
      end
   end
   sfb_pkg::sfb_sample_t prev_reg;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         prev_reg <= '0;
      end else if (xl_hit) begin
         prev_reg <= sample;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cfg_last_reg <= '0;
         dec_last_reg <= '0;
         cfg_pend_reg <= 1'b0;
      end else begin
         cfg_last_reg <= dev_cfg;
         dec_last_reg <= dec_reg[4:0];
         if (cfg_change && ctrl_reg[sfb_pkg::CFG_CHG_BIT]) begin
            cfg_pend_reg <= 1'b1;
         end else if (xl_hit) begin
            cfg_pend_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // word formation into the input queue
   sfb_pkg::sfb_word_t main_word;
   sfb_pkg::sfb_word_t aux_word;
   logic main_v;
   logic aux_v;
   always_comb begin
      main_word = '0;
      main_v = xl_hit;
      if (bio_only_state) begin
         main_word.tag = sfb_pkg::TAG_BIO_ONLY;
         main_word.data = {32'h0, sample.bio[15:8], sample.bio[7:0]};
      end else if (depth2x) begin
         main_v = xl_hit && half_reg;
         main_word.tag = sfb_pkg::TAG_XL_2X;
         main_word.data = {sample.z[15:8], sample.y[15:8], sample.x[15:8],
            prev_reg.z[15:8], prev_reg.y[15:8], prev_reg.x[15:8]};
      end else if (xl_only) begin
         main_word.tag = sfb_pkg::TAG_XL;
         main_word.data = {sample.z[15:8], sample.z[7:0], sample.y[15:8],
            sample.y[7:0], sample.x[15:8], sample.x[7:0]};
      end else begin
         main_word.tag = sfb_pkg::TAG_XL_BIO;
         main_word.data = {sample.bio[11:4], sample.bio[3:0], sample.z[11:8],
            sample.z[7:0], sample.y[11:4], sample.y[3:0], sample.x[11:8],
            sample.x[7:0]};
      end
   end
   always_comb begin
      aux_word.tag = sfb_pkg::TAG_TS;
      aux_word.data = {timestamp, cfg_pend_reg, dev_cfg.output_sample_rate, dev_cfg.bw,
         dev_cfg.hp_en, 1'b0, dev_cfg.fs, dec_reg[4:3],
         dec_reg[2:0]};
      aux_v = xl_hit && (ts_hit || cfg_pend_reg);
   end
   // priority: aux word, then main, then embedded results
   sfb_pkg::sfb_word_t q_in;
   logic q_v;
   logic q_rdy;
   logic emb_go;
   logic emb_en;
   // a main word that meets an aux word waits one cycle
   sfb_pkg::sfb_word_t held_reg;
   logic held_v_reg;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         held_v_reg <= 1'b0;
      end else begin
         held_v_reg <= aux_v && main_v;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (aux_v && main_v) begin
         held_reg <= main_word;
      end
   end
   always_comb begin
      case (emb_tag)
         sfb_pkg::TAG_FSE: emb_en = emb_reg[3];
         sfb_pkg::TAG_LRN_FLT: emb_en = emb_reg[2];
         sfb_pkg::TAG_LRN_FEAT: emb_en = emb_reg[2];
         sfb_pkg::TAG_LRN_RES: emb_en = emb_reg[1];
         sfb_pkg::TAG_STEP: emb_en = emb_reg[0];
         default: emb_en = 1'b0;
      endcase
   end
   assign emb_go = emb_valid && emb_en && !aux_v && !main_v
      && !held_v_reg;
   assign emb_ready = (q_rdy && !aux_v && !main_v && !held_v_reg)
      || (emb_valid && !emb_en);
   always_comb begin
      q_v = 1'b0;
      q_in = '0;
      if (aux_v) begin
         q_v = 1'b1;
         q_in = aux_word;
      end else if (held_v_reg) begin
         q_v = 1'b1;
         q_in = held_reg;
      end else if (main_v) begin
         q_v = 1'b1;
         q_in = main_word;
      end else if (emb_go) begin
         q_v = 1'b1;
         q_in = {emb_tag, emb_data};
      end
   end
   sfb_pkg::sfb_word_t q_out;
   logic q_ov;
   logic q_take;
   sfb_in_fifo #(.WIDTH($bits(sfb_pkg::sfb_word_t)), .DEPTH(sfb_pkg::IN_DEPTH))
      u_q (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(q_v),
      .in_ready(q_rdy),
      .in_data(q_in),
      .out_valid(q_ov),
      .out_ready(q_take),
      .out_data(q_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // main store and mode control
   sfb_pkg::sfb_word_t store [sfb_pkg::DEPTH];
   logic [6:0] wp_reg;
   logic [6:0] rp_reg;
   logic [7:0] cnt_reg;
   logic ovr_reg;
   logic [7:0] limit;
   logic full;
   logic store_en;
   logic push;
   logic pop;
   logic drop;
   logic trig_reg;
   logic rd_data;
   logic pop_req;
   assign limit = ctrl_reg[sfb_pkg::STOP_TH_BIT] ? {1'b0, level}
      : 8'(sfb_pkg::DEPTH);
   assign full = cnt_reg >= limit;
   // trigger: watermark reached; while bypassed, words seen are counted
   logic [7:0] seen_reg;
   always_ff @(posedge ref_clk) begin
      if (!rst_n || wr_ctrl) begin
         seen_reg <= 8'h00;
      end else if (q_ov && !trig_reg && seen_reg != 8'hff) begin
         seen_reg <= seen_reg + 8'h01;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n || wr_ctrl) begin
         trig_reg <= 1'b0;
      end else if (level != 7'h00 && (cnt_reg >= {1'b0, level}
         || seen_reg >= {1'b0, level})) begin
         trig_reg <= 1'b1;
      end
   end
   always_comb begin
      case (mode)
         sfb_pkg::MODE_STOP: store_en = 1'b1;
         sfb_pkg::MODE_CONT: store_en = 1'b1;
         sfb_pkg::MODE_CONT_TO_STOP: store_en = 1'b1;
         sfb_pkg::MODE_BYP_TO_CONT: store_en = trig_reg;
         sfb_pkg::MODE_BYP_TO_STOP: store_en = trig_reg;
         default: store_en = 1'b0;
      endcase
   end
   // stop kinds refuse when full, continuous kinds overwrite oldest
   logic stop_full;
   assign stop_full = full && (mode == sfb_pkg::MODE_STOP
      || mode == sfb_pkg::MODE_BYP_TO_STOP
      || (mode == sfb_pkg::MODE_CONT_TO_STOP && trig_reg));
   assign q_take = q_ov;
   assign push = q_ov && store_en && !stop_full;
   assign drop = push && full;
   assign rd_data = reg_rd && reg_addr == sfb_pkg::ADDR_Z_H;
   assign pop_req = rd_data && cnt_reg != 8'h00;
   assign pop = pop_req && !drop;
   always_ff @(posedge ref_clk) begin
      if (push) begin
         store[wp_reg] <= q_out;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !store_en) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= (8'(wp_reg) + 8'h01 >= limit) ? 7'h00 : wp_reg + 1'b1;
         end
         if (drop || pop) begin
            rp_reg <= (8'(rp_reg) + 8'h01 >= limit) ? 7'h00 : rp_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + 8'(push && !drop) - 8'(pop);
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !store_en) begin
         ovr_reg <= 1'b0;
      end else if (drop) begin
         ovr_reg <= 1'b1;
      end else if (pop) begin
         ovr_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status with block update hold and readback
   logic [7:0] stat1;
   logic [7:0] stat2_live;
   logic [7:0] stat2_hold_reg;
   logic hold_reg;
   logic block_data_update;
   assign block_data_update = gen_reg[sfb_pkg::BDU_BIT];
   assign stat1 = {cnt_reg >= {1'b0, level}, ovr_reg, 6'h00};
   assign stat2_live = cnt_reg;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         hold_reg <= 1'b0;
         stat2_hold_reg <= '0;
      end else if (reg_rd && reg_addr == sfb_pkg::ADDR_STAT1 && block_data_update) begin
         hold_reg <= 1'b1;
         stat2_hold_reg <= stat2_live;
      end else if (reg_rd && reg_addr == sfb_pkg::ADDR_STAT2) begin
         hold_reg <= 1'b0;
      end
   end
   sfb_pkg::sfb_word_t head;
   logic [47:0] head_data;
   assign head = store[rp_reg];
   assign head_data = head.data;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == sfb_pkg::ADDR_CTRL) begin
            reg_rdata <= ctrl_reg;
         end else if (reg_addr == sfb_pkg::ADDR_WTM) begin
            reg_rdata <= wtm_reg;
         end else if (reg_addr == sfb_pkg::ADDR_DEC) begin
            reg_rdata <= dec_reg;
         end else if (reg_addr == sfb_pkg::ADDR_EMB) begin
            reg_rdata <= emb_reg;
         end else if (reg_addr == sfb_pkg::ADDR_GEN) begin
            reg_rdata <= gen_reg;
         end else if (reg_addr == sfb_pkg::ADDR_STAT1) begin
            reg_rdata <= stat1;
         end else if (reg_addr == sfb_pkg::ADDR_STAT2) begin
            reg_rdata <= hold_reg ? stat2_hold_reg : stat2_live;
         end else if (reg_addr == sfb_pkg::ADDR_TAG) begin
            reg_rdata <= (cnt_reg == 8'h00) ? {sfb_pkg::TAG_EMPTY, 3'h0}
               : {head.tag, 3'h0};
         end else if (reg_addr >= sfb_pkg::ADDR_X_L
            && reg_addr <= sfb_pkg::ADDR_Z_H) begin
            reg_rdata <= (cnt_reg == 8'h00) ? 8'h00
               : head_data[8*(reg_addr - sfb_pkg::ADDR_X_L) +: 8];
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt routing
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         int_out <= 1'b0;
      end else begin
         int_out <= (stat1[7] && gen_reg[sfb_pkg::IRQ_WTM_BIT])
            || (ovr_reg && gen_reg[sfb_pkg::IRQ_OVR_BIT])
            || (cnt_reg[7] && gen_reg[sfb_pkg::IRQ_FULL_BIT]);
      end
   end
endmodule : sfb_top

// ### sfb_top_assertions.sv
// checker: port-level properties of the tagged sample buffer
module sfb_top_assertions (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic int_out
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   sequence s_rd(logic [7:0] a);
      reg_rd && reg_addr == a;
   endsequence
   sequence s_wr(logic [7:0] a);
      reg_wr && reg_addr == a;
   endsequence
   ////////////////////////////////////////
   a_unmapped_read_zero: assert property (s_rd(8'h00) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_tag_low_zero: assert property (s_rd(sfb_pkg::ADDR_TAG)
      |=> reg_rdata[2:1] == 2'b00) else $error("tag low bits not zero");
   a_tag_code_legal: assert property (s_rd(sfb_pkg::ADDR_TAG)
      |=> reg_rdata[7:3] inside {5'h00, 5'h02, 5'h03, 5'h04, 5'h12,
      5'h1a, 5'h1b, 5'h1c, 5'h1d, 5'h1e, 5'h1f})
      else $error("unknown tag code");
   a_ctrl_reserved_zero: assert property (s_rd(sfb_pkg::ADDR_CTRL)
      |=> reg_rdata[5] == 1'b0) else $error("control bit 5 not zero");
   a_dec_reserved_zero: assert property (s_rd(sfb_pkg::ADDR_DEC)
      |=> reg_rdata[7:5] == 3'h0) else $error("decimation top bits set");
   a_emb_reserved_zero: assert property (s_rd(sfb_pkg::ADDR_EMB)
      |=> reg_rdata[7:4] == 4'h0) else $error("enable top bits set");
   a_count_in_range: assert property (s_rd(sfb_pkg::ADDR_STAT2)
      |=> reg_rdata <= 8'h80) else $error("word count above 128");
   a_wtm_readback: assert property (s_wr(sfb_pkg::ADDR_WTM) ##1 !reg_wr
      ##1 s_rd(sfb_pkg::ADDR_WTM) |=> reg_rdata == $past(reg_wdata, 3))
      else $error("watermark readback differs");
   a_int_unrouted: assert property (reg_wr && reg_addr == sfb_pkg::ADDR_GEN
      && reg_wdata[3:1] == 3'h0 |-> ##2 !int_out)
      else $error("interrupt without routing");
endmodule : sfb_top_assertions

bind sfb_top sfb_top_assertions sfb_top_assertions_i (.ref_clk, .rst_n,
   .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .int_out);

// ### sfb_host_model.sv
// host model: register reads and writes over the strobe port
module sfb_host_model (
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic ref_clk,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   ////////////////////////////////////////
   // one write strobe; released lines show their inverse
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   // one read strobe; data taken the cycle after
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask : rd
   // status pair, first register before second
   task automatic rd_status(output logic [7:0] s1, output logic [7:0] s2);
      rd(sfb_pkg::ADDR_STAT1, s1);
      rd(sfb_pkg::ADDR_STAT2, s2);
   endtask : rd_status
endmodule : sfb_host_model

// ### testbench.sv
// testbench: register-level tests of the tagged sample buffer
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic odr_tick = 1'b0;
   logic bio_only_state = 1'b0;
   sfb_pkg::sfb_sample_t sample = 64'h1a2b_3c4d_5e6f_7081;
   logic [31:0] timestamp = 32'h0;
   sfb_pkg::sfb_cfg_t dev_cfg = '0;
   logic emb_valid = 1'b0;
   logic [4:0] emb_tag = 5'h00;
   logic [47:0] emb_data = 48'h0a0b0c0d0e0f;
   logic emb_ready;
   logic int_out;
   logic [7:0] rv;
   logic [7:0] s1;
   logic [7:0] s2;
   int n_errors = 0;
   int samples_checked = 0;
   logic [7:0] ra [4] = '{sfb_pkg::ADDR_CTRL, sfb_pkg::ADDR_WTM,
      sfb_pkg::ADDR_DEC, sfb_pkg::ADDR_EMB};
   logic [7:0] rm [4] = '{sfb_pkg::CTRL_MASK, 8'hff, sfb_pkg::DEC_MASK,
      sfb_pkg::EMB_MASK};
   always #4 ref_clk = ~ref_clk;
   always @(negedge ref_clk) timestamp <= timestamp + 32'h1;
   sfb_top sfb_top_i (.ref_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .odr_tick, .bio_only_state, .sample,
      .timestamp, .dev_cfg, .emb_valid, .emb_tag, .emb_data, .emb_ready,
      .int_out);
   sfb_host_model sfb_host_model_i (.ref_clk, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata);
   ////////////////////////////////////////
   task automatic stop_test();
      $display("checked %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] m,
         input logic [7:0] e);
      sfb_host_model_i.rd(a, rv);
      chk(rv & m, e);
   endtask : rchk
   task automatic st(input logic [7:0] m, input logic [7:0] e1,
         input logic [7:0] e2);
      sfb_host_model_i.rd_status(s1, s2);
      chk(s1 & m, e1);
      chk(s2, e2);
   endtask : st
   task automatic word(input logic [4:0] t, input logic [47:0] xb);
      rchk(sfb_pkg::ADDR_TAG, 8'hf8, {t, 3'h0});
      for (int i = 0; i < 6; i++) begin
         rchk(sfb_pkg::ADDR_X_L + 8'(i), 8'hff, xb[8*i +: 8]);
      end
   endtask : word
   task automatic tick(input int n);
      repeat (n) begin
         @(negedge ref_clk);
         odr_tick = 1'b1;
         @(negedge ref_clk);
         odr_tick = 1'b0;
      end
      repeat (6) @(negedge ref_clk);
   endtask : tick
   // bypass empties the store before each new setup
   task automatic cfg(input logic [7:0] c, input logic [7:0] w,
         input logic [7:0] d);
      sfb_host_model_i.wr(sfb_pkg::ADDR_CTRL, 8'h00);
      sfb_host_model_i.wr(sfb_pkg::ADDR_WTM, w);
      sfb_host_model_i.wr(sfb_pkg::ADDR_DEC, d);
      sfb_host_model_i.wr(sfb_pkg::ADDR_CTRL, c);
   endtask : cfg
   task automatic emb(input logic [4:0] t);
      @(negedge ref_clk);
      emb_valid = 1'b1;
      emb_tag = t;
      while (emb_ready !== 1'b1) @(negedge ref_clk);
      @(negedge ref_clk);
      emb_valid = 1'b0;
      emb_tag = ~t;
   endtask : emb
   ////////////////////////////////////////
   initial begin
      #100us;
      n_errors++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      stop_test();
   end
   initial begin
      repeat (12) @(negedge ref_clk);
      rst_n = 1'b1;
      sfb_host_model_i.wr(sfb_pkg::ADDR_GEN, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rchk(ra[i], 8'hff, 8'h00);
         sfb_host_model_i.wr(ra[i], 8'hff);
         rchk(ra[i], 8'hff, rm[i]);
         sfb_host_model_i.wr(ra[i], 8'h00);
      end
      rchk(8'h00, 8'hff, 8'h00);
      rchk(sfb_pkg::ADDR_TAG, 8'hf8, 8'h00);
      $display("test registers done");
      cfg(8'h06, 8'h84, 8'h00);
      tick(3);
      st(8'hc0, 8'h00, 8'h03);
      tick(1);
      st(8'hc0, 8'h80, 8'h04);
      word(sfb_pkg::TAG_XL, {sample.z, sample.y, sample.x});
      st(8'hc0, 8'h00, 8'h03);
      cfg(8'h06, 8'h00, 8'h00);
      tick(1);
      word(sfb_pkg::TAG_XL_BIO, {sample.bio[11:0], sample.z[11:0],
         sample.y[11:0], sample.x[11:0]});
      bio_only_state = 1'b1;
      cfg(8'h16, 8'h00, 8'h00);
      tick(1);
      word(sfb_pkg::TAG_BIO_ONLY, {32'h0, sample.bio});
      bio_only_state = 1'b0;
      cfg(8'h46, 8'h00, 8'h00);
      tick(4);
      st(8'h00, 8'h00, 8'h02);
      rchk(sfb_pkg::ADDR_TAG, 8'hf8, {sfb_pkg::TAG_XL_2X, 3'h0});
      $display("test formats done");
      for (int c = 0; c < 8; c++) begin
         cfg(8'h06, 8'h00, 8'(c));
         tick(2 << c);
         st(8'h00, 8'h00, (c == 7) ? 8'h00 : 8'h02);
      end
      for (int c = 1; c < 4; c++) begin
         cfg(8'h06, 8'h00, 8'(c << 3));
         tick(32);
         st(8'h00, 8'h00, (c == 1) ? 8'd64 : (c == 2) ? 8'd36 : 8'd33);
      end
      cfg(8'h86, 8'h00, 8'h00);
      dev_cfg.output_sample_rate = 4'h3;
      tick(1);
      st(8'h00, 8'h00, 8'h02);
      rchk(sfb_pkg::ADDR_TAG, 8'hf8, {sfb_pkg::TAG_TS, 3'h0});
      rchk(sfb_pkg::ADDR_X_L + 8'h01, 8'hff, 8'h98);
      $display("test rates done");
      cfg(8'h06, 8'h00, 8'h00);
      tick(130);
      st(8'hc0, 8'hc0, 8'h80);
      cfg(8'h01, 8'h00, 8'h00);
      tick(130);
      st(8'h40, 8'h00, 8'h80);
      cfg(8'h09, 8'h0a, 8'h00);
      tick(20);
      st(8'h80, 8'h80, 8'h0a);
      sfb_host_model_i.wr(sfb_pkg::ADDR_GEN, 8'h02);
      repeat (3) @(negedge ref_clk);
      chk({7'h0, int_out}, 8'h01);
      sfb_host_model_i.wr(sfb_pkg::ADDR_GEN, 8'h00);
      repeat (3) @(negedge ref_clk);
      chk({7'h0, int_out}, 8'h00);
      for (int m = 0; m < 2; m++) begin
         cfg(m ? 8'h07 : 8'h04, 8'h05, 8'h00);
         tick(12);
         st(8'h40, 8'h00, 8'h07);
      end
      cfg(8'h03, 8'h05, 8'h00);
      tick(130);
      st(8'hc0, 8'h80, 8'h80);
      $display("test limits done");
      cfg(8'h06, 8'h00, 8'h07);
      sfb_host_model_i.wr(sfb_pkg::ADDR_EMB, 8'h01);
      emb(sfb_pkg::TAG_STEP);
      emb(sfb_pkg::TAG_FSE);
      repeat (8) @(negedge ref_clk);
      st(8'h00, 8'h00, 8'h01);
      word(sfb_pkg::TAG_STEP, emb_data);
      sfb_host_model_i.wr(sfb_pkg::ADDR_GEN, 8'h01);
      sfb_host_model_i.rd(sfb_pkg::ADDR_STAT1, rv);
      emb(sfb_pkg::TAG_STEP);
      rchk(sfb_pkg::ADDR_STAT2, 8'hff, 8'h00);
      rchk(sfb_pkg::ADDR_STAT2, 8'hff, 8'h01);
      $display("test embedded done");
      stop_test();
   end
endmodule : testbench
